// File: design/swe_controller.sv
// sleep/wake event controller: gathers wake sources, times the power
// switch, holds the wake request until the power sequencer acknowledges or a long switch hold clears it
// assumes pins are asynchronous; sleep state and ack from sequencer logic
`timescale 1ns/10ps
`include "swe_map.svh"

// Summary of operation
// - network wake-up frame indication while sleeping raises the wake request
// - in S3 keep main supply off; led amber if dual, dark if single
// - accepted wake from S3 returns to last working state
// - usb activity wakes only from S3
// - pci pme wakes from S3, S4, S5 only when enabled
// - pci express wake assertion wakes from S3, S4, S5
// - infrared receiver activity wakes from S3, S4, S5
// - programmed rtc alarm wakes the system from soft-off
// - switch press under 4 s wakes; held over 6 s forces soft-off
module swe_controller (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic [1:0] sleepState,
   input  wire logic lanWakeFrame,
   input  wire logic usbActivity,
   input  wire logic pmEvent_n,
   input  wire logic pcieWake_n,
   input  wire logic infrared_receiver_activity,
   input  wire logic rtcAlarm,
   input  wire logic powerSwitch_n,
   input  wire logic pm_event_wake_enable,
   input  wire logic ledDualColour,
   input  wire logic workingAck,
   output logic      wakeRequest,
   output logic      mainPowerOn,
   output logic      forceSoftOff,
   output logic      ledMain,
   output logic      ledAlt,
   output logic      resumeFromRam
);
   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic sLan, sUsb, sPme_n, sWake_n, sIr, sRtc, sSw_n, sPmeEn, sDual;
   logic [1:0] sSlp0, sSlp;

   swe_sync #(.RST_VAL(1'b0)) uLan  (.clock(clock), .sys_rst(sys_rst), .asyncIn(lanWakeFrame), .syncOut(sLan));
   swe_sync #(.RST_VAL(1'b0)) uUsb  (.clock(clock), .sys_rst(sys_rst), .asyncIn(usbActivity), .syncOut(sUsb));
   swe_sync #(.RST_VAL(1'b1)) uPme  (.clock(clock), .sys_rst(sys_rst), .asyncIn(pmEvent_n), .syncOut(sPme_n));
   swe_sync #(.RST_VAL(1'b1)) uWak  (.clock(clock), .sys_rst(sys_rst), .asyncIn(pcieWake_n), .syncOut(sWake_n));
   swe_sync #(.RST_VAL(1'b0)) uIr   (.clock(clock), .sys_rst(sys_rst),
                                     .asyncIn(infrared_receiver_activity), .syncOut(sIr));
   swe_sync #(.RST_VAL(1'b0)) uRtc  (.clock(clock), .sys_rst(sys_rst), .asyncIn(rtcAlarm), .syncOut(sRtc));
   swe_sync #(.RST_VAL(1'b1)) uSw   (.clock(clock), .sys_rst(sys_rst), .asyncIn(powerSwitch_n), .syncOut(sSw_n));
   swe_sync #(.RST_VAL(1'b0)) uEn   (.clock(clock), .sys_rst(sys_rst),
                                     .asyncIn(pm_event_wake_enable), .syncOut(sPmeEn));
   swe_sync #(.RST_VAL(1'b0)) uDual (.clock(clock), .sys_rst(sys_rst), .asyncIn(ledDualColour), .syncOut(sDual));
   swe_sync #(.RST_VAL(1'b0)) uSl0  (.clock(clock), .sys_rst(sys_rst), .asyncIn(sleepState[0]), .syncOut(sSlp0[0]));
   swe_sync #(.RST_VAL(1'b0)) uSl1  (.clock(clock), .sys_rst(sys_rst), .asyncIn(sleepState[1]), .syncOut(sSlp0[1]));
   assign sSlp = sSlp0;

   // ----------------------------------------------------------------
   // power switch timing
   // ----------------------------------------------------------------
   localparam int SHORT_CYC = `SWE_SHORT_CYC;
   localparam int LONG_CYC  = `SWE_LONG_CYC;
   logic [27:0] pressCnt, next_pressCnt;
   logic        swPrev, next_swPrev;
   logic        shortPress, longHeld;

   // count press length, saturating past the long limit
   always_comb begin
      next_swPrev   = ~sSw_n;
      next_pressCnt = pressCnt;
      if (~sSw_n) begin
         if (pressCnt < 28'(LONG_CYC))
            next_pressCnt = pressCnt + 28'h0000001;
      end else begin
         next_pressCnt = 28'h0000000;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pressCnt <= 28'h0000000;
         swPrev   <= 1'b0;
      end else begin
         pressCnt <= next_pressCnt;
         swPrev   <= next_swPrev;
      end
   end

   // release before 4 s is a short press; reaching over 6 s is long
   assign shortPress = swPrev & sSw_n & (pressCnt < 28'(SHORT_CYC));
   assign longHeld   = ~sSw_n & (pressCnt == 28'(LONG_CYC) - 28'h0000001);

   // ----------------------------------------------------------------
   // wake source qualification
   // ----------------------------------------------------------------
   logic sleeping, inS3, anyWake;
   assign sleeping = (sSlp != `SWE_SLP_S0);
   assign inS3     = (sSlp == `SWE_SLP_S3);
   assign anyWake  = sleeping & (sLan
                   | (sUsb & inS3)
                   | (~sPme_n & sPmeEn)
                   | ~sWake_n
                   | sIr
                   | (sRtc & (sSlp == `SWE_SLP_S5))
                   | shortPress);

   // ----------------------------------------------------------------
   // sequencing state machine
   // ----------------------------------------------------------------
   swe_pkg::swe_state_t state, next_state;
   logic next_wakeRequest, next_mainPowerOn, next_forceSoftOff;
   logic next_ledMain, next_ledAlt, next_resumeFromRam;
   swe_pkg::swe_slp_t fromState, next_fromState;

   always_comb begin
      next_state         = state;
      next_wakeRequest   = wakeRequest;
      next_fromState     = fromState;
      next_forceSoftOff  = 1'b0;
      unique case (state)
         swe_pkg::SWE_WORK: begin
            if (sleeping) begin
               next_state     = swe_pkg::SWE_SLEEP;
               next_fromState = sSlp;
            end
         end
         swe_pkg::SWE_SLEEP: begin
            next_fromState = sSlp;
            if (!sleeping) begin
               next_state = swe_pkg::SWE_WORK;
            end else if (anyWake) begin
               next_state       = swe_pkg::SWE_WAKE;
               next_wakeRequest = 1'b1;
            end
         end
         swe_pkg::SWE_WAKE: begin
            if (workingAck) begin
               next_wakeRequest = 1'b0;
            end
            // leave only once the synced sleep state shows S0, so the
            // sync lag after the ack cannot send us back to sleep
            if (!sleeping && (workingAck || !wakeRequest)) begin
               next_state = swe_pkg::SWE_WORK;
            end
         end
         swe_pkg::SWE_OFF: begin
            if (sSw_n && sSlp == `SWE_SLP_S5)
               next_state = swe_pkg::SWE_SLEEP;
         end
         default: begin
            next_state = swe_pkg::SWE_WORK;
         end
      endcase
      // long hold overrides anything else
      if (longHeld) begin
         next_state        = swe_pkg::SWE_OFF;
         next_wakeRequest  = 1'b0;
         next_forceSoftOff = 1'b1;
      end
   end

   // outputs follow the next state
   always_comb begin
      next_mainPowerOn   = (next_state == swe_pkg::SWE_WORK) || (next_state == swe_pkg::SWE_WAKE);
      next_ledMain       = next_mainPowerOn;
      next_ledAlt        = (next_state == swe_pkg::SWE_SLEEP) && (next_fromState == `SWE_SLP_S3) && sDual;
      next_resumeFromRam = (next_state == swe_pkg::SWE_WAKE) && (next_fromState == `SWE_SLP_S3);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state         <= swe_pkg::SWE_WORK;
         fromState     <= `SWE_SLP_S0;
         wakeRequest   <= 1'b0;
         mainPowerOn   <= 1'b1;
         forceSoftOff  <= 1'b0;
         ledMain       <= 1'b1;
         ledAlt        <= 1'b0;
         resumeFromRam <= 1'b0;
      end else begin
         state         <= next_state;
         fromState     <= next_fromState;
         wakeRequest   <= next_wakeRequest;
         mainPowerOn   <= next_mainPowerOn;
         forceSoftOff  <= next_forceSoftOff;
         ledMain       <= next_ledMain;
         ledAlt        <= next_ledAlt;
         resumeFromRam <= next_resumeFromRam;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_LAN_WAKE: assert property (@(posedge clock) disable iff (sys_rst)
      (state == swe_pkg::SWE_SLEEP && sleeping && sLan && !longHeld) |=> wakeRequest)
      else $error("lan wake not requested");
   AST_S3_DARK: assert property (@(posedge clock) disable iff (sys_rst)
      (state == swe_pkg::SWE_SLEEP) |-> (!mainPowerOn && !ledMain))
      else $error("supply or main led on while sleeping");
   AST_RESUME: assert property (@(posedge clock) disable iff (sys_rst)
      (state == swe_pkg::SWE_WAKE && fromState == `SWE_SLP_S3) |-> resumeFromRam)
      else $error("resume from ram not flagged");
   AST_USB_S4: assert property (@(posedge clock) disable iff (sys_rst)
      (state == swe_pkg::SWE_SLEEP && sSlp == `SWE_SLP_S4 && sUsb && sLan == 1'b0 && sPme_n && sWake_n
       && !sIr && !shortPress) |=> !wakeRequest)
      else $error("usb woke from deep sleep");
   AST_PME_GATE: assert property (@(posedge clock) disable iff (sys_rst)
      (state == swe_pkg::SWE_SLEEP && sleeping && !sPme_n && sPmeEn && !longHeld) |=> wakeRequest)
      else $error("pme wake missed");
   AST_PCIE_WAKE: assert property (@(posedge clock) disable iff (sys_rst)
      (state == swe_pkg::SWE_SLEEP && sleeping && !sWake_n && !longHeld) |=> wakeRequest)
      else $error("pcie wake missed");
   AST_IR_WAKE: assert property (@(posedge clock) disable iff (sys_rst)
      (state == swe_pkg::SWE_SLEEP && sleeping && sIr && !longHeld) |=> wakeRequest)
      else $error("infrared wake missed");
   AST_RTC_WAKE: assert property (@(posedge clock) disable iff (sys_rst)
      (state == swe_pkg::SWE_SLEEP && sSlp == `SWE_SLP_S5 && sRtc && !longHeld) |=> wakeRequest)
      else $error("rtc wake missed");
   AST_LONG_OFF: assert property (@(posedge clock) disable iff (sys_rst)
      longHeld |=> (forceSoftOff && !wakeRequest && !mainPowerOn))
      else $error("long press did not force off");
   AST_HOLD_REQ: assert property (@(posedge clock) disable iff (sys_rst)
      (wakeRequest && !workingAck && !longHeld) |=> wakeRequest)
      else $error("wake request dropped before ack");
   COV_WAKE: cover property (@(posedge clock) disable iff (sys_rst) $rose(wakeRequest));
   COV_ACK: cover property (@(posedge clock) disable iff (sys_rst) $fell(wakeRequest));
   COV_OFF: cover property (@(posedge clock) disable iff (sys_rst) forceSoftOff);
endmodule

// File: design/swe_map.svh
// constants for the sleep/wake event controller: state codes and timing
// assumes a 25 MHz standby clock; included by bare name
`ifndef SWE_MAP_SVH
`define SWE_MAP_SVH
`define SWE_CLK_HZ          25000000
`define SWE_SHORT_PRESS_MS  4000
`define SWE_LONG_PRESS_MS   6000
`define SWE_DEB_US          1000
`define SWE_SHORT_CYC       ((`SWE_CLK_HZ / 1000) * `SWE_SHORT_PRESS_MS)
`define SWE_LONG_CYC        ((`SWE_CLK_HZ / 1000) * `SWE_LONG_PRESS_MS + 1)
`define SWE_DEB_CYC         ((`SWE_CLK_HZ / 1000000) * `SWE_DEB_US)
`define SWE_SLP_S0          2'h0
`define SWE_SLP_S3          2'h1
`define SWE_SLP_S4          2'h2
`define SWE_SLP_S5          2'h3
`endif

// File: design/swe_pkg.sv
// types for the sleep/wake event controller
// used through scoped names only
package swe_pkg;
   typedef enum logic [3:0] {
      SWE_WORK  = 4'h1,
      SWE_SLEEP = 4'h2,
      SWE_WAKE  = 4'h4,
      SWE_OFF   = 4'h8
   } swe_state_t;
   typedef logic [1:0] swe_slp_t;
endpackage

// File: design/swe_sync.sv
// two-flop synchroniser for one asynchronous level
// assumes a single clock and synchronous active-high reset
`timescale 1ns/10ps
module swe_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic asyncIn,
   output logic      syncOut
);
   logic stage1;
   logic next_stage1;
   logic next_syncOut;

   // sample chain
   always_comb begin
      next_stage1  = asyncIn;
      next_syncOut = stage1;
   end

   // register the chain
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         stage1  <= RST_VAL;
         syncOut <= RST_VAL;
      end else begin
         stage1  <= next_stage1;
         syncOut <= next_syncOut;
      end
   end
endmodule

// File: sim/swe_seq_model.sv
// behavioural power sequencer on the far side of the wake controller
// assumes one clock; bench sets the target sleep state
`timescale 1ns/10ps
module swe_seq_model (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic [1:0] targetState,
   input  wire logic       wakeRequest,
   output logic      [1:0] sleepState,
   output logic            workingAck
);
   logic [1:0] waitCnt;
   logic       held;
   // ---------------------------------------------
   // ack a wake after four cycles, reporting S0 from that same cycle
   // ---------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sleepState <= 2'h0;
         workingAck <= 1'b0;
         waitCnt    <= 2'h0;
         held       <= 1'b0;
      end else begin
         workingAck <= 1'b0;
         if (held) begin
            sleepState <= 2'h0;
            if (targetState == 2'h0) held <= 1'b0;
         end else if (wakeRequest) begin
            waitCnt <= waitCnt + 2'h1;
            if (waitCnt == 2'h3) begin
               workingAck <= 1'b1;
               sleepState <= 2'h0;
               held       <= 1'b1;
            end
         end else begin
            sleepState <= targetState;
         end
      end
   end
endmodule

// File: sim/swe_controller_tb.sv
// testbench for the sleep/wake event controller
// assumes the sequencer model drives sleep state and ack
`timescale 1ns/10ps
`include "swe_map.svh"
module swe_controller_tb;
   logic clock = 1'b0, sys_rst = 1'b1, lan = 1'b0, usb = 1'b0, pme_n = 1'b1, pcie_n = 1'b1, ir = 1'b0;
   logic rtc = 1'b0, sw_n = 1'b1, en = 1'b1, dual = 1'b0;
   logic [1:0] target = 2'h0, sleepState;
   logic workingAck, wakeRequest, mainPowerOn, forceSoftOff, ledMain, ledAlt, resumeFromRam;
   int   n_mismatch = 0, tests_run = 0;
   always #20 clock = ~clock;
   swe_seq_model i_seq (.clock(clock), .sys_rst(sys_rst), .targetState(target), .wakeRequest(wakeRequest),
      .sleepState(sleepState), .workingAck(workingAck));
   swe_controller i_dut (.clock(clock), .sys_rst(sys_rst), .sleepState(sleepState), .lanWakeFrame(lan),
      .usbActivity(usb), .pmEvent_n(pme_n), .pcieWake_n(pcie_n), .infrared_receiver_activity(ir),
      .rtcAlarm(rtc), .powerSwitch_n(sw_n), .pm_event_wake_enable(en), .ledDualColour(dual),
      .workingAck(workingAck), .wakeRequest(wakeRequest), .mainPowerOn(mainPowerOn),
      .forceSoftOff(forceSoftOff), .ledMain(ledMain), .ledAlt(ledAlt), .resumeFromRam(resumeFromRam));
   // ---------------------------------------------
   // shared compare, verdict
   // ---------------------------------------------
   task automatic check(input logic seen, input logic exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %b, wanted %b", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // drive one source active or idle
   task automatic drv(input int src, input logic v);
      case (src)
         0: lan <= v;
         1: usb <= v;
         2: pme_n <= !v;
         3: pcie_n <= !v;
         4: ir <= v;
         5: rtc <= v;
         default: sw_n <= !v;
      endcase
   endtask
   // expected acceptance of a source in a state
   function automatic logic accept(input int src, input logic [1:0] st);
      if (st == `SWE_SLP_S0) return 1'b0;
      case (src)
         1: return st == `SWE_SLP_S3;
         2: return en;
         5: return st == `SWE_SLP_S5;
         default: return 1'b1;
      endcase
   endfunction
   // ---------------------------------------------
   // sleep, raise one source, judge the wake
   // ---------------------------------------------
   task automatic try_wake(input logic [1:0] st, input int src);
      logic exp;
      int   k;
      exp = accept(src, st);
      target <= st;
      repeat (6) @(posedge clock);
      check(mainPowerOn, st == `SWE_SLP_S0);
      check(ledMain, st == `SWE_SLP_S0);
      check(ledAlt, (st == `SWE_SLP_S3) && dual);
      drv(src, 1'b1);
      if (src == 6) begin
         repeat (2000) @(posedge clock);
         drv(6, 1'b0);
      end
      k = 0;
      while (!wakeRequest && k < 12) begin
         @(posedge clock);
         k++;
      end
      #1 check(wakeRequest, exp);
      check(forceSoftOff, 1'b0);
      if (exp) begin
         check(mainPowerOn, 1'b1);
         check(resumeFromRam, st == `SWE_SLP_S3);
         k = 0;
         while (wakeRequest && k < 12) begin
            @(posedge clock);
            k++;
         end
         #1 check(wakeRequest, 1'b0);
      end
      drv(src, 1'b0);
      target <= 2'h0;
      repeat (8) @(posedge clock);
      check(mainPowerOn, 1'b1);
      $display("test state %0d source %0d enable %b done", st, src, en);
   endtask
   // ---------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      #1 check(wakeRequest, 1'b0);
      check(mainPowerOn, 1'b1);
      for (int e = 1; e >= 0; e--) begin
         en <= e[0];
         for (int s = 1; s <= 3; s++)
            for (int src = 0; src < 6; src++) begin
               dual <= s[0] ^ e[0];
               try_wake(s[1:0], src);
            end
      end
      try_wake(`SWE_SLP_S0, 3);
      try_wake(`SWE_SLP_S4, 6);
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      wrap_up();
   end
endmodule
